// file: hw/wss_pkg.sv
// Shared constants and carriers for the weld schedule sequencer.
// Assumes one 40 MHz clock and a mains zero-crossing pulse from outside.
`default_nettype none
package wss_pkg;
  localparam int CLK_HZ            = 40_000_000;
  localparam int CYC_W             = 8;
  localparam int SCALE_W           = 14;
  localparam int KA_W              = 15;
  localparam int ANG_W             = 8;
  localparam logic [7:0] ANG_MAX   = 8'h82;
  localparam logic [7:0] ANG_MIN   = 8'h1E;
  localparam logic [SCALE_W-1:0] SCALE_FULL = 14'h2710;
  localparam logic [KA_W-1:0] KA_MIN = 15'h0032;
  localparam logic [KA_W-1:0] KA_MAX = 15'h61A8;
  localparam logic [3:0] PULSE_MAX = 4'h9;
  localparam int PERIOD_50HZ_MS    = 20;
  localparam int PERIOD_60HZ_US    = 16_600;
  localparam int PERIOD_50HZ_CYC   = PERIOD_50HZ_MS * (CLK_HZ / 1000);
  localparam int PERIOD_60HZ_CYC   = (PERIOD_60HZ_US * (CLK_HZ / 1000)) / 1000;

  typedef enum logic [1:0] {WSS_SINGLE = 2'h0, WSS_REPEAT = 2'h1, WSS_SEAM = 2'h2} wss_mode_t;

  typedef enum logic [3:0] {
    WSS_IDLE  = 4'h0, WSS_PRE  = 4'h1, WSS_WAITF = 4'h3, WSS_SQUEEZE = 4'h2,
    WSS_H1    = 4'h6, WSS_C1   = 4'h7, WSS_H2    = 4'h5, WSS_C2   = 4'h4,
    WSS_C3    = 4'hC, WSS_H3   = 4'hD, WSS_HOLD  = 4'hF, WSS_OFF  = 4'hE,
    WSS_DONE  = 4'hA
  } wss_state_t;

  typedef struct packed {
    logic [CYC_W-1:0] pre_squeeze;
    logic [CYC_W-1:0] squeeze;
    logic [CYC_W-1:0] heat1;
    logic [CYC_W-1:0] cool1;
    logic [CYC_W-1:0] heat2;
    logic [CYC_W-1:0] cool2;
    logic [3:0]       pulses;
    logic [CYC_W-1:0] cool3;
    logic [CYC_W-1:0] heat3;
    logic [CYC_W-1:0] hold;
    logic [CYC_W-1:0] off;
  } wss_times_t;

  // Per heat block: 1 = constant current, 0 = open-loop firing angle
  typedef struct packed {
    logic       mixed;
    logic       prog_cc;
    logic [2:0] block_cc;
  } wss_regsel_t;

  typedef struct packed {
    logic [SCALE_W-1:0] scale;
    logic [KA_W-1:0]  ka;
  } wss_heat_t;
endpackage
`default_nettype wire

// file: hw/wss_tick.sv
// Mains-cycle tick from supply zero-crossing pulses.
// Assumes zero_cross pulses once per half-cycle, synchronous to clk.
`default_nettype none
module wss_tick (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Supply
  input  wire logic zero_cross,
  // Tick
  output logic      cycle_tick
);
  import wss_pkg::*;
  logic half_reg;

  // Two zero crossings make one full mains cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_reg <= 1'b0;
    end else if (zero_cross) begin
      half_reg <= ~half_reg;
    end
  end

  assign cycle_tick = zero_cross & half_reg;
endmodule
`default_nettype wire

// file: hw/wss_fire.sv
// Firing angle unit: open-loop scale mapping or current regulation.
// Assumes measured primary current; secondary = primary * turns_ratio / 16, in 10 A units, updated each half-cycle.
`default_nettype none
module wss_fire (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Control
  input  wire logic               heat_on,
  input  wire logic               cc_mode,
  input  wire logic               half_tick,
  input  wire wss_pkg::wss_heat_t setpoint,
  input  wire logic [wss_pkg::KA_W-1:0] primary_i,
  input  wire logic [7:0]         turns_ratio,
  // Output
  output logic [wss_pkg::ANG_W-1:0] fire_angle,
  output logic                      fire_en
);
  import wss_pkg::*;
  logic [KA_W-1:0]  sec_i;
  logic [KA_W-1:0]  sp_ka;
  logic [SCALE_W-1:0] sp_scale;
  logic [7:0]       ang_reg;
  logic [7:0]       ol_ang;

  function automatic logic [7:0] scale_to_angle(input logic [SCALE_W-1:0] s);
    logic [31:0] t;
    t = 32'(ANG_MAX) - (32'(s) * 32'h64) / 32'(SCALE_FULL);
    return t[7:0];
  endfunction

  // Clip setpoints into the accepted ranges
  assign sp_scale = (setpoint.scale > SCALE_FULL) ? SCALE_FULL : setpoint.scale;
  assign sp_ka  = (setpoint.ka < KA_MIN) ? KA_MIN :
                  (setpoint.ka > KA_MAX) ? KA_MAX : setpoint.ka;
  assign ol_ang = scale_to_angle(sp_scale);
  assign sec_i  = KA_W'((32'(primary_i) * 32'(turns_ratio)) >> 4);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ang_reg <= ANG_MAX;
    end else if (!heat_on) begin
      ang_reg <= ANG_MAX;
    end else if (!cc_mode) begin
      ang_reg <= ol_ang;
    end else if (half_tick) begin
      // Smaller angle means more current
      if (sec_i < sp_ka && ang_reg > ANG_MIN) begin
        ang_reg <= ang_reg - 8'h01;
      end else if (sec_i > sp_ka && ang_reg < ANG_MAX) begin
        ang_reg <= ang_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fire_en <= 1'b0;
    end else begin
      fire_en <= heat_on;
    end
  end

  assign fire_angle = ang_reg;

  property p_angle_range;
    @(posedge clk) disable iff (!rstn) ang_reg >= ANG_MIN && ang_reg <= ANG_MAX;
  endproperty
  a_angle_range: assert property (p_angle_range) else $error("firing angle out of range");

  property p_open_loop_map;
    @(posedge clk) disable iff (!rstn) heat_on && !cc_mode |=> ang_reg == $past(ol_ang);
  endproperty
  a_open_loop_map: assert property (p_open_loop_map) else $error("open-loop angle not mapped");
endmodule
`default_nettype wire

// file: hw/wss_top.sv
// Weld schedule sequencer: interval stepping, gun, weld complete, heat select.
// Assumes synchronous inputs and a zero-crossing pulse per half mains cycle.
`default_nettype none
module wss_top #(
  parameter int PULSE_W = 4
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Start side
  input  wire logic                  start_in,
  input  wire wss_pkg::wss_mode_t    weld_mode,
  input  wire logic                  force_reached_in,
  input  wire logic                  weld_error_in,
  // Program
  input  wire wss_pkg::wss_times_t   times,
  input  wire wss_pkg::wss_regsel_t  regsel,
  input  wire wss_pkg::wss_heat_t    heat1_sp,
  input  wire wss_pkg::wss_heat_t    heat2_sp,
  input  wire wss_pkg::wss_heat_t    heat3_sp,
  input  wire wss_pkg::wss_heat_t    monitor_ref,
  input  wire logic [wss_pkg::CYC_W-1:0] user_delay,
  input  wire logic [wss_pkg::CYC_W-1:0] user_width,
  // Power side
  input  wire logic                  zero_cross,
  input  wire logic [wss_pkg::KA_W-1:0] primary_i,
  input  wire logic [7:0]            turns_ratio,
  output logic [wss_pkg::ANG_W-1:0]  fire_angle,
  output logic                       fire_en,
  output logic                       solenoid_out,
  output logic                       weld_complete_out,
  output logic                       user_timed_out,
  output logic                       heat_active,
  output wss_pkg::wss_heat_t         monitor_ref_out,
  output logic                       monitor_enable,
  output logic [1:0]                 heat_block
);
  import wss_pkg::*;
  wss_state_t        state_reg, state_next;
  logic [CYC_W-1:0]  cnt_reg;
  logic [PULSE_W-1:0] pulse_reg;
  logic              series_reg;
  logic              start_seen_reg;
  logic              err_reg;
  logic              sol_reg;
  logic              cmpl_reg;
  logic [CYC_W:0]    ut_cnt_reg;
  logic              ut_run_reg;
  logic              ut_reg;
  wss_heat_t         mon_reg;
  logic              cycle_tick;
  logic              load;
  logic [CYC_W-1:0]  load_val;
  logic              cnt_done;
  logic              heat_on;
  logic              cc_sel;
  wss_heat_t         sp_sel;
  logic [1:0]        blk;
  logic              last_pulse;

  wss_tick u_tick (
    .clk        (clk),
    .rstn       (rstn),
    .zero_cross (zero_cross),
    .cycle_tick (cycle_tick)
  );

  // Interval length belonging to a state
  function automatic logic [CYC_W-1:0] ival(input wss_state_t s, input wss_times_t t);
    case (s)
      WSS_PRE:  return t.pre_squeeze;
      WSS_SQUEEZE: return t.squeeze;
      WSS_H1:   return t.heat1;
      WSS_C1:   return t.cool1;
      WSS_H2:   return t.heat2;
      WSS_C2:   return t.cool2;
      WSS_C3:   return t.cool3;
      WSS_H3:   return t.heat3;
      WSS_HOLD: return t.hold;
      WSS_OFF:  return t.off;
      default:  return '0;
    endcase
  endfunction

  assign cnt_done   = (cnt_reg == '0) || (cnt_reg == CYC_W'(1) && cycle_tick);
  assign last_pulse = (pulse_reg >= PULSE_W'(times.pulses)) || (times.pulses == '0);

  // Next state after the main heat block finishes a pulse
  function automatic wss_state_t after_h2(input wss_times_t t, input logic last);
    if (!last && t.cool2 != '0) return WSS_C2;
    if (!last) return WSS_H2;
    if (t.heat3 != '0 && t.cool3 != '0) return WSS_C3;
    if (t.heat3 != '0) return WSS_H3;
    return WSS_HOLD;
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WSS_IDLE: begin
        if (start_in && !start_seen_reg && !err_reg) begin
          state_next = (weld_mode == WSS_REPEAT && series_reg) ? WSS_WAITF : WSS_PRE;
        end
      end
      WSS_PRE:   if (cnt_done) state_next = WSS_WAITF;
      WSS_WAITF: if (force_reached_in) state_next = WSS_SQUEEZE;
      WSS_SQUEEZE: begin
        if (cnt_done) begin
          if (times.heat1 != '0) state_next = WSS_H1;
          else state_next = WSS_H2;
        end
      end
      WSS_H1:  if (cnt_done) state_next = (times.cool1 != '0) ? WSS_C1 : WSS_H2;
      WSS_C1:  if (cnt_done) state_next = WSS_H2;
      WSS_H2: begin
        if (weld_mode == WSS_SEAM && !start_in) state_next = WSS_HOLD;
        else if (cnt_done) begin
          if (weld_mode == WSS_SEAM) state_next = (times.cool2 != '0) ? WSS_C2 : WSS_H2;
          else state_next = after_h2(times, last_pulse);
        end
      end
      WSS_C2: begin
        if (weld_mode == WSS_SEAM && !start_in) state_next = WSS_HOLD;
        else if (cnt_done) state_next = WSS_H2;
      end
      WSS_C3:  if (cnt_done) state_next = WSS_H3;
      WSS_H3:  if (cnt_done) state_next = WSS_HOLD;
      WSS_HOLD: begin
        if (cnt_done) begin
          if (weld_mode == WSS_REPEAT && start_in && !err_reg) state_next = WSS_OFF;
          else state_next = WSS_DONE;
        end
      end
      WSS_OFF:  if (cnt_done) state_next = start_in ? WSS_WAITF : WSS_DONE;
      WSS_DONE: state_next = WSS_IDLE;
      default:  state_next = WSS_IDLE;
    endcase
  end

  assign load     = (state_next != state_reg) || (state_reg == WSS_H2 && cnt_done && state_next == WSS_H2);
  assign load_val = ival(state_next, times);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= WSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cycle_tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CYC_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulse_reg <= '0;
    end else if (state_reg == WSS_SQUEEZE) begin
      pulse_reg <= PULSE_W'(1);
    end else if (state_reg == WSS_H2 && cnt_done && !last_pulse) begin
      pulse_reg <= pulse_reg + PULSE_W'(1);
    end
  end

  // Series stays marked while start is held across repeat spots
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      series_reg <= 1'b0;
    end else if (!start_in) begin
      series_reg <= 1'b0;
    end else if (state_reg == WSS_SQUEEZE && weld_mode == WSS_REPEAT) begin
      series_reg <= 1'b1;
    end
  end

  // A single schedule per start edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_seen_reg <= 1'b0;
    end else if (!start_in) begin
      start_seen_reg <= 1'b0;
    end else if (state_reg == WSS_IDLE && state_next != WSS_IDLE) begin
      start_seen_reg <= 1'b1;
    end
  end

  // Error latched per schedule; new arrival wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_reg <= 1'b0;
    end else if (weld_error_in) begin
      err_reg <= 1'b1;
    end else if (state_reg == WSS_IDLE && !start_in) begin
      err_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sol_reg <= 1'b0;
    end else if (state_next == WSS_DONE || state_next == WSS_OFF || state_next == WSS_IDLE) begin
      sol_reg <= 1'b0;
    end else begin
      sol_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmpl_reg <= 1'b0;
    end else if (state_reg == WSS_HOLD && cnt_done) begin
      cmpl_reg <= !err_reg && !weld_error_in;
    end else if (state_reg == WSS_IDLE && !start_in) begin
      cmpl_reg <= 1'b0;
    end
  end

  // User timed output: delay then width, counted from squeeze start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ut_run_reg <= 1'b0;
      ut_cnt_reg <= '0;
      ut_reg     <= 1'b0;
    end else if (state_next == WSS_SQUEEZE && state_reg != WSS_SQUEEZE) begin
      ut_run_reg <= 1'b1;
      ut_cnt_reg <= '0;
      ut_reg     <= (user_delay == '0) && (user_width != '0);
    end else if (ut_run_reg && cycle_tick) begin
      ut_cnt_reg <= ut_cnt_reg + (CYC_W+1)'(1);
      ut_reg     <= (ut_cnt_reg + (CYC_W+1)'(1) >= {1'b0, user_delay}) &&
                    (ut_cnt_reg + (CYC_W+1)'(1) < {1'b0, user_delay} + {1'b0, user_width});
      if (ut_cnt_reg + (CYC_W+1)'(1) >= {1'b0, user_delay} + {1'b0, user_width}) begin
        ut_run_reg <= 1'b0;
      end
    end
  end

  // Monitoring reference kept apart from regulation setpoints
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= monitor_ref;
    end
  end

  assign heat_on = (state_reg == WSS_H1) || (state_reg == WSS_H2) || (state_reg == WSS_H3);
  assign blk     = (state_reg == WSS_H1) ? 2'h0 : (state_reg == WSS_H3) ? 2'h2 : 2'h1;
  assign cc_sel  = regsel.mixed ? regsel.block_cc[blk] : regsel.prog_cc;
  assign sp_sel  = (blk == 2'h0) ? heat1_sp : (blk == 2'h2) ? heat3_sp : heat2_sp;

  wss_fire u_fire (
    .clk         (clk),
    .rstn        (rstn),
    .heat_on     (heat_on),
    .cc_mode     (cc_sel),
    .half_tick   (zero_cross),
    .setpoint    (sp_sel),
    .primary_i   (primary_i),
    .turns_ratio (turns_ratio),
    .fire_angle  (fire_angle),
    .fire_en     (fire_en)
  );

  assign solenoid_out      = sol_reg;
  assign weld_complete_out = cmpl_reg;
  assign user_timed_out    = ut_reg;
  assign heat_active       = fire_en;
  assign monitor_ref_out   = mon_reg;
  assign monitor_enable    = fire_en;
  assign heat_block        = blk;

  sequence s_hold_end;
    state_reg == WSS_HOLD && cnt_done;
  endsequence

  property p_no_heat_idle;
    @(posedge clk) disable iff (!rstn)
      (state_reg inside {WSS_PRE, WSS_SQUEEZE, WSS_HOLD, WSS_OFF, WSS_WAITF}) |=> !fire_en;
  endproperty
  a_no_heat_idle: assert property (p_no_heat_idle) else $error("current outside heat");

  property p_wait_force;
    @(posedge clk) disable iff (!rstn) state_reg == WSS_WAITF && !force_reached_in |=> state_reg == WSS_WAITF;
  endproperty
  a_wait_force: assert property (p_wait_force) else $error("squeeze without force");

  property p_cmpl_good;
    @(posedge clk) disable iff (!rstn) s_hold_end ##0 (!err_reg && !weld_error_in) |=> cmpl_reg;
  endproperty
  a_cmpl_good: assert property (p_cmpl_good) else $error("weld complete missing");

  property p_cmpl_bad;
    @(posedge clk) disable iff (!rstn) s_hold_end ##0 err_reg |=> !cmpl_reg;
  endproperty
  a_cmpl_bad: assert property (p_cmpl_bad) else $error("weld complete despite error");

  property p_sol_off;
    @(posedge clk) disable iff (!rstn) s_hold_end ##0 (state_next != WSS_HOLD) |=> !sol_reg;
  endproperty
  a_sol_off: assert property (p_sol_off) else $error("gun not opened after hold");

  property p_single_once;
    @(posedge clk) disable iff (!rstn) state_reg == WSS_IDLE && start_seen_reg |=> state_reg == WSS_IDLE;
  endproperty
  a_single_once: assert property (p_single_once) else $error("restart without new start");

  property p_seam_cancel;
    @(posedge clk) disable iff (!rstn) state_reg == WSS_H2 && weld_mode == WSS_SEAM && !start_in |=> state_reg == WSS_HOLD;
  endproperty
  a_seam_cancel: assert property (p_seam_cancel) else $error("seam pulse not cancelled");

  property p_ut_launch;
    @(posedge clk) disable iff (!rstn) state_reg == WSS_WAITF && force_reached_in |=> ut_run_reg;
  endproperty
  a_ut_launch: assert property (p_ut_launch) else $error("user output not launched");

  property p_off_repeat;
    @(posedge clk) disable iff (!rstn) state_reg == WSS_OFF |-> weld_mode == WSS_REPEAT || $past(weld_mode) == WSS_REPEAT;
  endproperty
  a_off_repeat: assert property (p_off_repeat) else $error("off outside repeat");
endmodule
`default_nettype wire

// file: dv/wss_far_model.sv
// Far-side model: mains zero crossings, gun force switch, current sensor.
// Assumes the sequencer's solenoid_out, fire_en and fire_angle on clk.
`default_nettype none
module wss_far_model #(
  parameter int HALF  = 10,
  parameter int F_LAT = 30
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // From sequencer and bench
  input  wire logic                      solenoid_out,
  input  wire logic                      fire_en,
  input  wire logic [wss_pkg::ANG_W-1:0] fire_angle,
  input  wire logic                      force_block,
  // To sequencer
  output logic                           zero_cross,
  output logic                           force_reached_in,
  output logic [wss_pkg::KA_W-1:0]       primary_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int zc_cnt = 0;
  int f_cnt  = 0;
  initial begin
    zero_cross = 1'b0;
    force_reached_in = 1'b0;
  end
  // Half cycle shortened to HALF clocks so runs stay short
  always @(negedge clk) begin
    zc_cnt = rstn ? (zc_cnt + 1) % HALF : 0;
    zero_cross <= rstn && (zc_cnt == 0);
    // Gun needs time to close; switch opens with the valve
    f_cnt = solenoid_out ? f_cnt + 1 : 0;
    force_reached_in <= (f_cnt > F_LAT) && !force_block;
  end
  // Less current at larger angles, none without firing
  assign primary_i = fire_en ? 15'(16'd140 - 16'(fire_angle)) * 15'd40 : '0;
endmodule
`default_nettype wire

// file: dv/wss_top_tb.sv
// Self-checking bench for the weld schedule sequencer.
// Assumes wss_far_model supplies mains ticks, force switch and current.
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module wss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wss_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, start_in = 1'b0, weld_error_in = 1'b0, force_block = 1'b0;
  wss_mode_t   weld_mode = WSS_SINGLE;
  wss_times_t  tm = '0;
  wss_regsel_t rs = '0;
  wss_heat_t   sp[3], mref, mref_o;
  logic [7:0]  udel = 8'h00, uwid = 8'h01, ratio = 8'h10, angle;
  logic [14:0] prim_i;
  logic        zc, force_in, fire_en, sol, cmpl, uto, hact, mon_en, fire_q, force_seen, early, uto_seen;
  logic [1:0]  hblk, blk_q;
  logic [1:0]  order_q[$];
  logic [7:0]  ang[3];
  int          failures = 0, n_tests = 0, cyc = 0, seed = 32'h1459c4cb, r, t0, g1;
  initial for (int b = 0; b < 3; b++) sp[b] = '0;
  initial mref = '0;
  always #12.5 clk = ~clk;
  wss_top #(.PULSE_W(4)) uut (.clk(clk), .rstn(rstn), .start_in(start_in), .weld_mode(weld_mode),
    .force_reached_in(force_in), .weld_error_in(weld_error_in), .times(tm), .regsel(rs),
    .heat1_sp(sp[0]), .heat2_sp(sp[1]), .heat3_sp(sp[2]), .monitor_ref(mref), .user_delay(udel),
    .user_width(uwid), .zero_cross(zc), .primary_i(prim_i), .turns_ratio(ratio), .fire_angle(angle),
    .fire_en(fire_en), .solenoid_out(sol), .weld_complete_out(cmpl), .user_timed_out(uto),
    .heat_active(hact), .monitor_ref_out(mref_o), .monitor_enable(mon_en), .heat_block(hblk));
  wss_far_model #(.HALF(10), .F_LAT(30)) far (.clk(clk), .rstn(rstn), .solenoid_out(sol),
    .fire_en(fire_en), .fire_angle(angle), .force_block(force_block), .zero_cross(zc),
    .force_reached_in(force_in), .primary_i(prim_i));
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      conclude();
    end
    fire_q <= fire_en;
    if (force_in) force_seen <= 1'b1;
    if (uto) uto_seen <= 1'b1;
    if ((fire_en || uto) && !force_seen && !force_in) early <= 1'b1;
    if (fire_en && !fire_q) begin
      order_q.push_back(hblk);
      blk_q <= hblk;
    end
    if (fire_en && fire_q) ang[blk_q] <= angle;
  end
  function automatic logic pick(int w);
    return (w == 0) ? sol : (w == 1) ? fire_en : cmpl;
  endfunction
  function automatic int fold();
    int s = 0;
    foreach (order_q[i]) s = s * 4 + order_q[i] + 1;
    return s;
  endfunction
  function automatic int exp_sig(wss_times_t t);
    int s = 0;
    if (t.heat1 != 0) s = 1;
    repeat (t.pulses) s = s * 4 + 2;
    if (t.heat3 != 0) s = s * 4 + 3;
    return s;
  endfunction
  task automatic await(input int w, input logic v);
    int n = 0;
    while (pick(w) !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK(pick(w), v)
  endtask
  task automatic run(input logic err, input logic blk);
    @(negedge clk);
    order_q.delete();
    force_seen = 1'b0;
    early = 1'b0;
    uto_seen = 1'b0;
    force_block = blk;
    start_in = 1'b1;
    await(0, 1'b1);
    if (blk) begin
      repeat (300) @(negedge clk);
      `CHK(early, 1'b0)
      force_block = 1'b0;
    end
    if (err) begin
      await(1, 1'b1);
      weld_error_in = 1'b1;
      @(negedge clk);
      weld_error_in = 1'b0;
    end
    await(0, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(cmpl, !err)
    `CHK(early, 1'b0)
    `CHK(uto_seen, 1'b1)
    `CHK(fold(), exp_sig(tm))
  endtask
  task automatic rel(input string s);
    repeat (200) @(negedge clk);
    `CHK(sol, 1'b0)
    start_in = 1'b0;
    repeat (5) @(negedge clk);
    `CHK(cmpl, 1'b0)
    $display("test %s done", s);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    // Squeeze kept at one mains cycle or more, cools non-zero
    tm = '{pre_squeeze: 8'h02, squeeze: 8'h01, heat1: 8'h01, cool1: 8'h01, heat2: 8'h01, cool2: 8'h01,
           pulses: 4'h2, cool3: 8'h01, heat3: 8'h01, hold: 8'h02, off: 8'h03};
    sp[1].scale = SCALE_FULL;
    repeat (20) @(negedge clk);
    `CHK(angle, ANG_MAX)
    `CHK(sol, 1'b0)
    rstn = 1'b1;
    run(1'b0, 1'b1);
    `CHK(ang[0], ANG_MAX)
    `CHK(ang[1], ANG_MIN)
    rel("single");
    run(1'b1, 1'b0);
    rel("error");
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      tm.heat1 = r[2] ? 8'h02 : 8'h00;
      tm.heat3 = r[3] ? 8'h01 : 8'h00;
      tm.pulses = (r[5:4] == 2'h0) ? 4'h1 : {2'h0, r[5:4]};
      tm.heat2 = {6'h0, r[7:6]} + 8'h01;
      rs = r[12:8];
      // Delay kept below the shortest schedule so the pulse is seen
      udel = {6'h0, r[17:16]};
      ratio = {4'h1, r[21:18]};
      for (int b = 0; b < 3; b++) sp[b].scale = r[13 + b] ? SCALE_FULL : '0;
      run(1'b0, 1'b0);
      for (int b = 0; b < 3; b++) begin
        if ((b == 1) || (b == 0 && r[2]) || (b == 2 && r[3])) begin
          `CHK(ang[b] >= ANG_MIN && ang[b] <= ANG_MAX, 1'b1)
          if (!(rs.mixed ? rs.block_cc[b] : rs.prog_cc)) `CHK(ang[b], r[13 + b] ? ANG_MIN : ANG_MAX)
        end
      end
      rel("random");
    end
    mref = wss_heat_t'($random(seed));
    sp[1] = '0;
    repeat (2) @(negedge clk);
    `CHK(mref_o, mref)
    weld_mode = WSS_REPEAT;
    tm.pre_squeeze = 8'h08;
    start_in = 1'b1;
    await(0, 1'b1);
    t0 = cyc;
    await(1, 1'b1);
    g1 = cyc - t0;
    await(0, 1'b0);
    t0 = cyc;
    await(0, 1'b1);
    `CHK(cyc - t0 >= 40, 1'b1)
    t0 = cyc;
    await(1, 1'b1);
    `CHK(cyc - t0 < g1 - 100, 1'b1)
    start_in = 1'b0;
    await(0, 1'b0);
    $display("test repeat done");
    weld_mode = WSS_SEAM;
    rs = '0;
    tm.heat1 = 8'h00;
    tm.heat2 = 8'h20;
    repeat (20) @(negedge clk);
    start_in = 1'b1;
    await(1, 1'b1);
    `CHK(mon_en, 1'b1)
    `CHK(hact, 1'b1)
    `CHK(hblk, 2'h1)
    repeat (30) @(negedge clk);
    start_in = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(fire_en, 1'b0)
    await(0, 1'b0);
    $display("test seam done");
    conclude();
  end
endmodule
`default_nettype wire
